/* File: hdl/tsi_pkg.sv */
// Purpose: Shared constants and types for the connection memory decode block
// Assumes: Four serial streams of 32 eight-bit channels each
// Notes: Word layout of one connection memory entry is fixed here
//
// Functional notes
// - Loopback bit set: received channel data is replaced by own transmit data.
// - Entry delay bit: low variable delay, high constant delay.
// - Processor channel bit set: entry low byte is sent instead of switched data.
// - Processor channel bit clear: address fields name the switched source slot.
// - Control output bit appears on its pin one channel time early.
// - Control bits go out in stream order, stream 0 first.
// - Output enable bit set drives the channel only while the control register enable bit is set; clear floats the transmit pin.
// - Entry bits 8 and 7 give the source stream number.
// - Entry bits 4 down to 0 give the source channel number.
// - A frame carries channels 0 to 31 on every stream.
package tsi_pkg;
  localparam int STREAMS = 4;
  localparam int CHANNELS = 32;
  localparam int BITS = 8;
  localparam int ST_W = 2;
  localparam int CH_W = 5;
  localparam int IDX_W = ST_W + CH_W;
  localparam int POS_W = CH_W + 3;
  localparam int ENTRY_W = 16;
  localparam int ENTRIES = STREAMS * CHANNELS;
  localparam int LOOPBACK_BIT = 15;
  localparam int DELAY_BIT = 14;
  localparam int PROC_BIT = 13;
  localparam int CONTROL_OUT_BIT = 12;
  localparam int OE_BIT = 11;
  localparam int SRC_ST_HI = 8;
  localparam int SRC_ST_LO = 7;
  localparam int SRC_CH_HI = 4;
  localparam int SRC_CH_LO = 0;
  localparam int PROC_HI = 7;
  localparam int ADR_W = 12;
  localparam logic [2:0] CONN_REGION = 3'h0;
  localparam logic [ADR_W-1:0] STATUS_ADDR = 12'h0200;
  localparam logic [ADR_W-1:0] CONTROL_ADDR = 12'h0204;
  localparam logic CONTROL_RESET = 1'b1;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [ENTRY_W-1:0] ENTRY_RESET = 16'h0000;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [ENTRY_W-1:0] data;
    logic [1:0] sel;
  } wr_req_t;

  typedef struct packed {
    logic [14:0] zero;
    logic bank;
    logic [7:0] frames;
    logic [POS_W-1:0] pos;
  } status_t;
endpackage

/* File: hdl/tsi_connection_memory_decode.sv */
// Purpose: Time slot switch core driven by a per-channel connection memory
// Assumes: Serial clock, frame pulse and data arrive unsynchronised
// Notes: Connection memory is written over classic Wishbone
`timescale 1ns/1ns
module tsi_connection_memory_decode #(
  parameter int STREAMS = tsi_pkg::STREAMS
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tdm_clk_i,
  input wire logic frame_i,
  input wire logic [STREAMS-1:0] rx_i,
  output logic [STREAMS-1:0] tx_o,
  output logic [STREAMS-1:0] tx_oe_o,
  output logic control_channel_output_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [tsi_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  localparam int SW = STREAMS + 2;
  localparam int EW = tsi_pkg::ENTRY_W;
  localparam int PW = tsi_pkg::POS_W;
  localparam int CW = tsi_pkg::CH_W;
  localparam int IW = tsi_pkg::IDX_W;

  // Pin synchronisers: frame, serial clock, data
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic tclk_prev_q;
  wire [SW-1:0] sync_in = {frame_i, tdm_clk_i, rx_i};
  wire frame_s = sync2_q[SW-1];
  wire tclk_s = sync2_q[SW-2];
  wire [STREAMS-1:0] rx_s = sync2_q[STREAMS-1:0];
  wire bit_edge = tclk_s & ~tclk_prev_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      tclk_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= sync_in;
      sync2_q <= sync1_q;
      tclk_prev_q <= tclk_s;
    end
  end

  // Bit position within the frame, 32 channels of 8 bits
  logic [PW-1:0] pos_q;
  logic bank_q;
  logic [7:0] frames_q;
  wire [PW-1:0] cur_pos = frame_s ? '0 : pos_q + 1'b1;
  wire [CW-1:0] cur_ch = cur_pos[PW-1:3];
  wire [2:0] cur_bit = cur_pos[2:0];
  wire [CW-1:0] next_ch = cur_ch + 1'b1;
  wire [CW-1:0] early_ch = cur_ch + 5'h0002;
  wire byte_end = bit_edge & (cur_bit == tsi_pkg::LAST_BIT);
  wire frame_start = bit_edge & (cur_pos == '0);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pos_q <= '0;
      bank_q <= 1'b0;
      frames_q <= 8'h00;
    end
    else if (bit_edge)
    begin
      pos_q <= cur_pos;
      if (frame_start)
      begin
        bank_q <= ~bank_q;
        frames_q <= frames_q + 8'h01;
      end
    end
  end

  // Connection memory and data memory, both flip-flops
  logic [EW-1:0] cmem_q [tsi_pkg::ENTRIES];
  logic [7:0] dmem_q [2][tsi_pkg::ENTRIES];
  logic [6:0] rx_sh_q [STREAMS];
  logic [7:0] tx_byte_q [STREAMS];
  logic [STREAMS-1:0] oe_q;
  logic [STREAMS-1:0] ctl_vec_q;
  logic enable_q;

  // Per-stream decode of the entries for the current, next and next-but-one channels
  logic [7:0] tx_next [STREAMS];
  logic [7:0] wr_byte [STREAMS];
  logic [STREAMS-1:0] oe_next;
  logic [STREAMS-1:0] ctl_next;
  logic [STREAMS-1:0] loop_cur;

  genvar gs;
  generate
    for (gs = 0; gs < STREAMS; gs++)
    begin : g_dec
      wire [tsi_pkg::ST_W-1:0] sid = tsi_pkg::ST_W'(gs);
      wire [EW-1:0] ent = cmem_q[{sid, next_ch}];
      wire [EW-1:0] ent_early = cmem_q[{sid, early_ch}];
      wire [EW-1:0] ent_cur = cmem_q[{sid, cur_ch}];
      wire [tsi_pkg::ST_W-1:0] src_st =
        ent[tsi_pkg::SRC_ST_HI:tsi_pkg::SRC_ST_LO];
      wire [CW-1:0] src_ch =
        ent[tsi_pkg::SRC_CH_HI:tsi_pkg::SRC_CH_LO];
      wire [IW-1:0] src_idx = {src_st, src_ch};
      // Slot 0 loads before the frame turns, so nothing of it is in yet
      wire wrap = next_ch == '0;
      wire fresh_ok = ~wrap & (src_ch <= cur_ch);
      wire prev_bank = wrap ? bank_q : ~bank_q;
      // Variable delay takes this frame's byte once it has arrived
      wire var_bank = fresh_ok ? bank_q : prev_bank;
      wire rd_bank = ent[tsi_pkg::DELAY_BIT] ? prev_bank : var_bank;
      // Byte stored on this same edge comes straight from wr_byte
      wire bypass = (rd_bank == bank_q) & (src_ch == cur_ch);
      wire [7:0] switched = bypass ? wr_byte[src_st] :
        dmem_q[rd_bank][src_idx];
      assign tx_next[gs] = ent[tsi_pkg::PROC_BIT] ?
        ent[tsi_pkg::PROC_HI:0] : switched;
      assign oe_next[gs] = ent[tsi_pkg::OE_BIT];
      assign ctl_next[gs] = ent_early[tsi_pkg::CONTROL_OUT_BIT];
      assign loop_cur[gs] = ent_cur[tsi_pkg::LOOPBACK_BIT];
      // Loopback byte is the one sent during this channel
      assign wr_byte[gs] = loop_cur[gs] ? tx_byte_q[gs] :
        {rx_sh_q[gs], rx_s[gs]};
    end
  endgenerate

  // Serial receive, data memory write, transmit load
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int s = 0; s < STREAMS; s++)
      begin
        rx_sh_q[s] <= 7'h00;
        tx_byte_q[s] <= 8'h00;
      end
      oe_q <= '0;
      ctl_vec_q <= '0;
    end
    else if (bit_edge)
    begin
      for (int s = 0; s < STREAMS; s++)
      begin
        rx_sh_q[s] <= {rx_sh_q[s][5:0], rx_s[s]};
        if (byte_end)
        begin
          dmem_q[bank_q][{s[tsi_pkg::ST_W-1:0], cur_ch}] <= wr_byte[s];
          tx_byte_q[s] <= tx_next[s];
        end
      end
      if (byte_end)
      begin
        oe_q <= oe_next;
        ctl_vec_q <= ctl_next;
      end
    end
  end

  // Pin outputs, all registered
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_o <= '0;
      tx_oe_o <= '0;
      control_channel_output_o <= 1'b0;
    end
    else if (bit_edge)
    begin
      for (int s = 0; s < STREAMS; s++)
      begin
        tx_o[s] <= tx_byte_q[s][3'h7 - cur_bit];
      end
      tx_oe_o <= oe_q & {STREAMS{enable_q}};
      // Two bit times per stream, stream 0 first
      control_channel_output_o <= ctl_vec_q[cur_bit[2:1]];
    end
  end

  // Wishbone slave decode
  wire [2:0] region = wb_adr_i[tsi_pkg::ADR_W-1:IW+2];
  wire conn_hit = region == tsi_pkg::CONN_REGION;
  wire status_hit = wb_adr_i == tsi_pkg::STATUS_ADDR;
  wire control_hit = wb_adr_i == tsi_pkg::CONTROL_ADDR;
  wire [IW-1:0] wb_idx = wb_adr_i[IW+1:2];
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_conn = wb_req & wb_we_i & conn_hit;
  logic buf_ready;
  wire ack_d = wb_req & (~wr_conn | buf_ready);
  tsi_pkg::status_t status_w;
  assign status_w = '{zero: '0, bank: bank_q, frames: frames_q, pos: pos_q};
  wire [31:0] rd_d = conn_hit ? {16'h0000, cmem_q[wb_idx]} :
                     status_hit ? status_w :
                     control_hit ? {31'h0000_0000, enable_q} : 32'h0000_0000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      enable_q <= tsi_pkg::CONTROL_RESET;
    end
    else
    begin
      wb_ack_o <= ack_d;
      wb_dat_o <= (ack_d & ~wb_we_i) ? rd_d : 32'h0000_0000;
      if (ack_d & wb_we_i & control_hit & wb_sel_i[0])
      begin
        enable_q <= wb_dat_i[0];
      end
    end
  end

  // Two-entry write buffer; drains except while entries are being read
  tsi_pkg::wr_req_t buf_q [2];
  logic wptr_q;
  logic rptr_q;
  logic [1:0] cnt_q;
  tsi_pkg::wr_req_t push_w;
  assign push_w = '{idx: wb_idx, data: wb_dat_i[EW-1:0], sel: wb_sel_i[1:0]};
  assign buf_ready = cnt_q != 2'h2;
  wire buf_valid = cnt_q != 2'h0;
  wire drain_ready = ~byte_end;
  wire push = wr_conn & buf_ready;
  wire pop = buf_valid & drain_ready;
  tsi_pkg::wr_req_t head;
  assign head = buf_q[rptr_q];
  wire [EW-1:0] old_ent = cmem_q[head.idx];
  wire [EW-1:0] merged = {head.sel[1] ? head.data[15:8] : old_ent[15:8],
                          head.sel[0] ? head.data[7:0] : old_ent[7:0]};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      cnt_q <= 2'h0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end
    else
    begin
      if (push)
      begin
        buf_q[wptr_q] <= push_w;
        wptr_q <= ~wptr_q;
      end
      if (pop)
      begin
        rptr_q <= ~rptr_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < tsi_pkg::ENTRIES; i++)
      begin
        cmem_q[i] <= tsi_pkg::ENTRY_RESET;
      end
    end
    else if (pop)
    begin
      cmem_q[head.idx] <= merged;
    end
  end
endmodule

/* File: tb/tsi_decode_checker.sv */
// Purpose: Port checks for the connection memory decode block
// Assumes: Serial clock rise shows at the outputs 3 to 4 clocks late
// Notes: Keeps its own copy of the serial bit position
`timescale 1ns/1ns
module tsi_decode_checker #(
  parameter int STREAMS = tsi_pkg::STREAMS
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tdm_clk_i,
  input wire logic frame_i,
  input wire logic [STREAMS-1:0] tx_o,
  input wire logic [STREAMS-1:0] tx_oe_o,
  input wire logic control_channel_output_o,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  logic tq;
  logic sy;
  logic [3:0] cnt;
  logic [7:0] pos;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Edge memory cleared in reset, as a design sync stage may be
  always_ff @(posedge clk_i)
  begin
    tq <= !rst_i && tdm_clk_i;
    sy <= !rst_i && (sy || frame_i);
    if (rst_i)
      cnt <= 4'hf;
    else if (tdm_clk_i && !tq)
      cnt <= 4'h0;
    else if (cnt != 4'hf)
      cnt <= cnt + 4'h1;
    if (tdm_clk_i && !tq)
      pos <= frame_i ? 8'h00 : pos + 8'h01;
  end
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  a_ack_bound: assert property (wb_stb_i && !wb_ack_o |-> ##[1:6] wb_ack_o)
    else $error("request not answered");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_out_reset: assert property ($fell(rst_i) |->
    tx_oe_o == '0 && !control_channel_output_o)
    else $error("outputs active after reset");
  a_tx_timing: assert property ($changed(tx_o) |-> cnt inside {[2:5]})
    else $error("transmit moved off the serial rise");
  a_oe_channel: assert property (
    sy && $changed(tx_oe_o) |-> pos[2:0] == 3'h0)
    else $error("enable moved inside a channel");
  a_cco_pairs: assert property (
    sy && $changed(control_channel_output_o) |->
    !pos[0] && cnt inside {[2:5]})
    else $error("control bit moved inside a pair");
endmodule
bind tsi_connection_memory_decode tsi_decode_checker #(.STREAMS(STREAMS))
  u_chk (.clk_i(clk_i), .rst_i(rst_i), .tdm_clk_i(tdm_clk_i),
  .frame_i(frame_i), .tx_o(tx_o), .tx_oe_o(tx_oe_o),
  .control_channel_output_o(control_channel_output_o),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

/* File: tb/tdm_partner.sv */
// Purpose: Serial stream source facing the switch
// Assumes: One bit time is 16 system clocks
// Notes: Byte sent is frame parity, stream, channel
`timescale 1ns/1ns
module tdm_partner
(
  input wire logic clk_i,
  output logic tdm_clk_o,
  output logic frame_o,
  output logic [3:0] rx_o,
  output logic mid_o,
  output logic [7:0] pos_o,
  output logic [7:0] fnum_o
);
  logic [3:0] div_q;
  logic [7:0] b;
  initial {div_q, tdm_clk_o, pos_o, fnum_o} = '0;
  always @(posedge clk_i)
  begin
    div_q <= div_q + 4'h1;
    tdm_clk_o <= (div_q == 4'h7) || (tdm_clk_o && div_q != 4'hf);
    if (div_q == 4'hf)
      {fnum_o, pos_o} <= {fnum_o, pos_o} + 16'h0001;
  end
  // Data moves on the fall, so it is steady at every rise
  always_comb
    for (int s = 0; s < 4; s++)
    begin
      b = {fnum_o[0], 2'(s), pos_o[7:3]};
      rx_o[s] = b[~pos_o[2:0]];
    end
  assign frame_o = pos_o == 8'h00;
  assign mid_o = div_q == 4'he;
endmodule

/* File: tb/tsi_connection_memory_decode_tb.sv */
// Purpose: Bench for the connection memory decode block
// Assumes: Partner sends 16 clocks per serial bit
// Notes: Frame 3 is captured whole and compared
`timescale 1ns/1ns
module tsi_connection_memory_decode_tb;
  logic clk_i, rst_i, stb, we, tclk, frm, mid, ack, ctl;
  logic [3:0] rx, tx, oe, sel;
  logic [11:0] adr;
  logic [31:0] wdat, dat, rdat;
  logic [7:0] pos, fnum;
  logic [15:0] ent [4][32];
  logic [7:0] cap [4][32];
  logic cap_oe [4][32];
  logic cap_ctl [256];
  logic [6:0] ti [7] = '{7'h0a, 7'h0b, 7'h7f, 7'h34, 7'h59, 7'h40, 7'h25};
  logic [15:0] te [7] = '{16'h0903, 16'h4903, 16'h385a, 16'hb8a5,
    16'h4894, 16'h099f, 16'h3033};
  int mismatches, checks;
  tsi_connection_memory_decode u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .tdm_clk_i(tclk), .frame_i(frm), .rx_i(rx), .tx_o(tx), .tx_oe_o(oe),
    .control_channel_output_o(ctl), .wb_cyc_i(stb), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat), .wb_ack_o(ack));
  tdm_partner u_far (.clk_i(clk_i), .tdm_clk_o(tclk), .frame_o(frm),
    .rx_o(rx), .mid_o(mid), .pos_o(pos), .fnum_o(fnum));
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] g, e);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
      @(posedge clk_i);
    while (ack !== 1'b1 && ++n < 40);
    rdat = dat;
    stb <= 1'b0;
    @(posedge clk_i);
    mismatches += int'(n >= 40);
  endtask
  // Loopback sources are only processor channels, so one level suffices
  function automatic logic [7:0] exp_byte(int s, int c, int f);
    logic [15:0] e;
    e = ent[s][c];
    if (e[13])
      return e[7:0];
    if (ent[e[8:7]][e[4:0]][15])
      return exp_byte(e[8:7], e[4:0], f);
    return {(e[14] || e[4:0] >= c) ^ f[0], e[8:7], e[4:0]};
  endfunction
  always @(posedge clk_i)
    if (mid && fnum == 8'h03)
      for (int s = 0; s < 4; s++)
      begin
        cap[s][pos[7:3]][~pos[2:0]] = tx[s];
        cap_oe[s][pos[7:3]] = oe[s];
        cap_ctl[pos] = ctl;
      end
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Five frames of 4096 clocks fit well inside this span
  initial
  begin
    #200000;
    mismatches++;
    test_done();
  end
  initial
  begin
    {rst_i, stb, we, adr, wdat, sel} = {3'h4, 44'h0, 4'h3};
    mismatches = 0;
    checks = 0;
    foreach (ent[s, c])
      ent[s][c] = 16'h0000;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 12'h204, 32'h0);
    chk("control", rdat, 32'h0000_0001);
    wb(1'b0, 12'h300, 32'h0);
    chk("unmapped", rdat, 32'h0000_0000);
    foreach (ti[i])
    begin
      ent[ti[i][6:5]][ti[i][4:0]] = te[i];
      wb(1'b1, {3'h0, ti[i], 2'h0}, {16'h0, te[i]});
    end
    repeat (4) @(posedge clk_i);
    wb(1'b0, 12'h0d0, 32'h0);
    chk("entry", rdat[15:0], 16'hb8a5);
    $display("test registers done");
    wait (fnum == 8'h04);
    foreach (cap[s, c])
    begin
      chk("oe", cap_oe[s][c], ent[s][c][11]);
      if (ent[s][c][11])
        chk("tx", cap[s][c], exp_byte(s, c, 3));
    end
    for (int p = 0; p < 256; p++)
      chk("ctl", cap_ctl[p], ent[p[2:1]][(p / 8 + 1) % 32][12]);
    $display("test frame done");
    test_done();
  end
endmodule
